// File: include/kgd_pkg.sv
// constants, types and state records for the knock gesture detector
// What this block does
// - slope is half the sample-to-sample difference
// - global enable bit gates all knock recognition
// - single knock: rise then fall within impact
// - pulse lasts silence window, latch until read
// - second knock starts after silence, before gap
// - second knock must also fall within impact
// - per-axis enable bits gate detection
// - unsigned 5-bit threshold per axis, both signs
// - highest priority axis that overshoots is chosen
// - impact 4 samples at 0, else 8 per step
// - silence 2 samples at 0, else 4 per step
// - tracked-axis overshoot in silence kills double knock
// - gap 16 samples at 0, else 32 per step
// - gap timer starts when silence ends
// - each event routed to each line separately
// - status shows any, single and double flags
// - status shows sign and the knock axis
// - mode bit enables double-knock detection
// - latch targets single or double per mode
// - latched sign and axis held until read
// - latch acts only for routed events
package kgd_pkg;

  localparam int unsigned SMP_W = 16;
  localparam int unsigned THR_SHIFT = SMP_W - 1 - 5;

  // register offsets
  localparam logic [7:0] OFS_CFG0    = 8'h17;
  localparam logic [7:0] OFS_CFG1    = 8'h18;
  localparam logic [7:0] OFS_CFG2    = 8'h19;
  localparam logic [7:0] OFS_ZTHR    = 8'h1a;
  localparam logic [7:0] OFS_STATUS  = 8'h1c;
  localparam logic [7:0] OFS_ALLSRC  = 8'h1d;
  localparam logic [7:0] OFS_FUNC_EN = 8'h50;
  localparam logic [7:0] OFS_TIMING  = 8'h5a;
  localparam logic [7:0] OFS_MOTION  = 8'h5b;
  localparam logic [7:0] OFS_ROUTE_A = 8'h5e;
  localparam logic [7:0] OFS_ROUTE_B = 8'h5f;

  // field positions
  localparam int unsigned B_LATCH   = 0;
  localparam int unsigned B_XEN     = 1;
  localparam int unsigned B_GLOBAL  = 7;
  localparam int unsigned B_MODE    = 7;
  localparam int unsigned B_RT_ONE  = 6;
  localparam int unsigned B_RT_TWO  = 3;
  localparam int unsigned B_PRIO    = 5;
  localparam int unsigned B_SIL     = 2;
  localparam int unsigned B_GAP     = 4;
  localparam int unsigned B_ST_ANY  = 6;
  localparam int unsigned B_ST_ONE  = 5;
  localparam int unsigned B_ST_TWO  = 4;
  localparam int unsigned B_ST_SIGN = 3;

  // reset values
  localparam logic [7:0] RST_REG = 8'h00;

  // window lengths in sample periods
  localparam logic [8:0] IMP_BASE = 9'h004;
  localparam logic [8:0] IMP_STEP = 9'h008;
  localparam logic [8:0] SIL_BASE = 9'h002;
  localparam logic [8:0] SIL_STEP = 9'h004;
  localparam logic [8:0] GAP_BASE = 9'h010;
  localparam logic [8:0] GAP_STEP = 9'h020;

  typedef enum logic [2:0] {
    KGD_IDLE    = 3'h0,
    KGD_IMPACT1 = 3'h1,
    KGD_SILENCE = 3'h3,
    KGD_GAP     = 3'h2,
    KGD_IMPACT2 = 3'h6
  } kgd_phase_e;

  typedef struct packed {
    logic [2:0][SMP_W-1:0] prev;
    logic [2:0]            over;
    logic [2:0]            neg;
    logic                  tick;
  } kgd_slope_s;

endpackage

// File: include/kgd_if.sv
// carrier between the detector core and the slope unit
`timescale 1ns/1ps
interface kgd_if;
  logic                                 sample_valid;
  logic [2:0][kgd_pkg::SMP_W-1:0]       accel;
  logic [2:0][4:0]                      level;
  logic [2:0]                           over;
  logic [2:0]                           neg;
  logic                                 tick;

  modport core
  (
    output sample_valid,
    output accel,
    output level,
    input  over,
    input  neg,
    input  tick
  );

  modport slope
  (
    input  sample_valid,
    input  accel,
    input  level,
    output over,
    output neg,
    output tick
  );
endinterface

// File: verilog/kgd_slope.sv
// per-axis slope and threshold compare for the knock detector
`timescale 1ns/1ps
module kgd_slope
(
  input wire logic clock,
  input wire logic rst_b,
  kgd_if.slope     sif
);

  kgd_pkg::kgd_slope_s st_q;
  kgd_pkg::kgd_slope_s st_d;

  // first sample after reset compares against zero, as the filter does
  always_comb
  begin
    logic signed [kgd_pkg::SMP_W:0]   diff;
    logic signed [kgd_pkg::SMP_W-1:0] slope;
    logic [kgd_pkg::SMP_W-1:0]        mag;
    logic [kgd_pkg::SMP_W-1:0]        thr;
    diff  = '0;
    slope = '0;
    mag   = '0;
    thr   = '0;
    st_d  = st_q;
    st_d.tick = sif.sample_valid;
    for (int i = 0; i < 3; i++)
    begin
      diff  = $signed({sif.accel[i][kgd_pkg::SMP_W-1], sif.accel[i]})
            - $signed({st_q.prev[i][kgd_pkg::SMP_W-1], st_q.prev[i]});
      slope = diff[kgd_pkg::SMP_W:1];
      mag   = slope[kgd_pkg::SMP_W-1] ? -slope : slope;
      thr   = {1'b0, sif.level[i], {kgd_pkg::THR_SHIFT{1'b0}}};
      if (sif.sample_valid)
      begin
        st_d.prev[i] = sif.accel[i];
        st_d.over[i] = mag > thr;
        st_d.neg[i]  = slope[kgd_pkg::SMP_W-1];
      end
    end
  end

  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign sif.over = st_q.over;
  assign sif.neg  = st_q.neg;
  assign sif.tick = st_q.tick;

endmodule

// File: verilog/kgd_top.sv
// knock gesture detector: registers, window timing, status and interrupts
`timescale 1ns/1ps
module kgd_top
(
  input  wire logic                          clock,
  input  wire logic                          rst_b,
  input  wire logic                          sample_valid,
  input  wire logic [kgd_pkg::SMP_W-1:0]     accel_x,
  input  wire logic [kgd_pkg::SMP_W-1:0]     accel_y,
  input  wire logic [kgd_pkg::SMP_W-1:0]     accel_z,
  input  wire logic                          reg_wr,
  input  wire logic                          reg_rd,
  input  wire logic [7:0]                    reg_addr,
  input  wire logic [7:0]                    reg_wdata,
  output logic      [7:0]                    reg_rdata,
  output logic                               irq_line_a,
  output logic                               irq_line_b
);

  typedef struct packed {
    logic [7:0]          knock_config_0;
    logic [7:0]          knock_config_1;
    logic [7:0]          knock_config_2;
    logic [7:0]          zaxis_and_orient_threshold;
    logic [7:0]          functions_enable;
    logic [7:0]          knock_timing_reg;
    logic [7:0]          motion_threshold_reg;
    logic [7:0]          route_line_a_reg;
    logic [7:0]          route_line_b_reg;
    kgd_pkg::kgd_phase_e phase;
    logic [8:0]          cnt;
    logic [1:0]          axis;
    logic                prev_over;
    logic                cap_neg;
    logic                st_any;
    logic                st_one;
    logic                st_two;
    logic                st_sign;
    logic [2:0]          st_axis;
    logic                latch_one;
    logic                latch_two;
    logic                pulse_one;
    logic                pulse_two;
    logic [8:0]          pcnt;
    logic [7:0]          rdata;
    logic                irq_a;
    logic                irq_b;
  } kgd_core_s;

  kgd_core_s st_q;
  kgd_core_s st_d;

  kgd_if sif ();

  // the slope unit sees the raw samples and the live thresholds
  assign sif.sample_valid = sample_valid;
  assign sif.accel        = {accel_z, accel_y, accel_x};
  assign sif.level        = {st_q.zaxis_and_orient_threshold[4:0],
                             st_q.knock_config_2[4:0],
                             st_q.knock_config_1[4:0]};

  kgd_slope u_slope
  (
    .clock (clock),
    .rst_b (rst_b),
    .sif   (sif)
  );

  // axis ordering, most important first; codes 6 and 7 fold onto 0
  function automatic logic [5:0] prio_order(input logic [2:0] code);
    case (code)
      3'h0:    prio_order = {2'h0, 2'h1, 2'h2};
      3'h1:    prio_order = {2'h1, 2'h0, 2'h2};
      3'h2:    prio_order = {2'h0, 2'h2, 2'h1};
      3'h3:    prio_order = {2'h2, 2'h0, 2'h1};
      3'h4:    prio_order = {2'h1, 2'h2, 2'h0};
      3'h5:    prio_order = {2'h2, 2'h1, 2'h0};
      default: prio_order = {2'h0, 2'h1, 2'h2};
    endcase
  endfunction

  // window length from a field: base at zero, else field times step
  function automatic logic [8:0] win_len(input logic [3:0] f,
                                         input logic [8:0] base,
                                         input logic [8:0] step);
    logic [12:0] prod;
    prod = 13'({9'h000, f} * {4'h0, step});
    if (f == 4'h0)
      win_len = base;
    else
      win_len = prod[8:0];
  endfunction

  logic [2:0] axis_en;
  logic [2:0] cand;
  logic [5:0] order;
  logic [8:0] imp_len;
  logic [8:0] sil_len;
  logic [8:0] gap_len;
  logic       global_on;
  logic       latch_sel;
  logic       mode_two;
  logic       rd_clear;

  // decoded configuration
  always_comb
  begin
    axis_en   = st_q.knock_config_0[kgd_pkg::B_XEN +: 3];
    cand      = sif.over & axis_en;
    order     = prio_order(st_q.knock_config_1[kgd_pkg::B_PRIO +: 3]);
    imp_len   = win_len({2'h0, st_q.knock_timing_reg[1:0]},
                        kgd_pkg::IMP_BASE, kgd_pkg::IMP_STEP);
    sil_len   = win_len({2'h0, st_q.knock_timing_reg[kgd_pkg::B_SIL +: 2]},
                        kgd_pkg::SIL_BASE, kgd_pkg::SIL_STEP);
    gap_len   = win_len(st_q.knock_timing_reg[kgd_pkg::B_GAP +: 4],
                        kgd_pkg::GAP_BASE, kgd_pkg::GAP_STEP);
    global_on = st_q.functions_enable[kgd_pkg::B_GLOBAL];
    latch_sel = st_q.knock_config_0[kgd_pkg::B_LATCH];
    mode_two  = st_q.motion_threshold_reg[kgd_pkg::B_MODE];
    rd_clear  = reg_rd && (reg_addr == kgd_pkg::OFS_STATUS ||
                           reg_addr == kgd_pkg::OFS_ALLSRC);
  end

  // next state: register writes, detector sequence, status, interrupts
  always_comb
  begin
    logic       over_sel;
    logic       rise;
    logic       ev_one;
    logic       ev_two;
    logic       rt_one;
    logic       rt_two;
    logic       lat_one;
    logic       lat_two;
    logic [1:0] pick;
    logic [8:0] cnt_n;
    logic       found;
    over_sel = 1'b0;
    rise     = 1'b0;
    ev_one   = 1'b0;
    ev_two   = 1'b0;
    rt_one   = 1'b0;
    rt_two   = 1'b0;
    lat_one  = 1'b0;
    lat_two  = 1'b0;
    pick     = 2'h0;
    cnt_n    = 9'(st_q.cnt + 9'h001);
    found    = 1'b0;
    st_d     = st_q;

    // register writes
    if (reg_wr)
    begin
      case (reg_addr)
        kgd_pkg::OFS_CFG0:    st_d.knock_config_0 = reg_wdata;
        kgd_pkg::OFS_CFG1:    st_d.knock_config_1 = reg_wdata;
        kgd_pkg::OFS_CFG2:    st_d.knock_config_2 = reg_wdata;
        kgd_pkg::OFS_ZTHR:    st_d.zaxis_and_orient_threshold = reg_wdata;
        kgd_pkg::OFS_FUNC_EN: st_d.functions_enable = reg_wdata;
        kgd_pkg::OFS_TIMING:  st_d.knock_timing_reg = reg_wdata;
        kgd_pkg::OFS_MOTION:  st_d.motion_threshold_reg = reg_wdata;
        kgd_pkg::OFS_ROUTE_A: st_d.route_line_a_reg = reg_wdata;
        kgd_pkg::OFS_ROUTE_B: st_d.route_line_b_reg = reg_wdata;
        default:              st_d.knock_config_0 = st_q.knock_config_0;
      endcase
    end

    // walk up from the lowest rank so the highest ranked hit wins
    for (int i = 0; i < 3; i++)
    begin
      if (cand[order[2*i +: 2]])
      begin
        pick  = order[2*i +: 2];
        found = 1'b1;
      end
    end

    // the tracked axis, once the sequence has chosen one
    over_sel = sif.over[st_q.axis] && axis_en[st_q.axis];

    // sequence steps only on a new sample
    if (!global_on)
    begin
      st_d.phase = kgd_pkg::KGD_IDLE;
      st_d.cnt   = 9'h000;
    end
    else if (sif.tick)
    begin
      rise = over_sel && !st_q.prev_over;
      st_d.prev_over = found ? 1'b1 : over_sel;
      case (st_q.phase)
        kgd_pkg::KGD_IDLE:
        begin
          // edge only, so a long overshoot cannot retrigger
          if (found && !st_q.prev_over)
          begin
            st_d.axis    = pick;
            st_d.cap_neg = sif.neg[pick];
            st_d.cnt     = 9'h000;
            st_d.phase   = kgd_pkg::KGD_IMPACT1;
          end
        end
        kgd_pkg::KGD_IMPACT1:
        begin
          if (!over_sel)
          begin
            ev_one   = 1'b1;
            st_d.cnt = 9'h000;
            if (mode_two)
              st_d.phase = kgd_pkg::KGD_SILENCE;
            else
              st_d.phase = kgd_pkg::KGD_IDLE;
          end
          else if (cnt_n >= imp_len)
            st_d.phase = kgd_pkg::KGD_IDLE;
          else
            st_d.cnt = cnt_n;
        end
        kgd_pkg::KGD_SILENCE:
        begin
          if (over_sel)
            st_d.phase = kgd_pkg::KGD_IDLE;
          else if (cnt_n >= sil_len)
          begin
            st_d.cnt   = 9'h000;
            st_d.phase = kgd_pkg::KGD_GAP;
          end
          else
            st_d.cnt = cnt_n;
        end
        kgd_pkg::KGD_GAP:
        begin
          if (rise)
          begin
            st_d.cnt     = 9'h000;
            st_d.cap_neg = sif.neg[st_q.axis];
            st_d.phase   = kgd_pkg::KGD_IMPACT2;
          end
          else if (cnt_n >= gap_len)
            st_d.phase = kgd_pkg::KGD_IDLE;
          else
            st_d.cnt = cnt_n;
        end
        kgd_pkg::KGD_IMPACT2:
        begin
          if (!over_sel)
          begin
            ev_two     = mode_two;
            st_d.phase = kgd_pkg::KGD_IDLE;
          end
          else if (cnt_n >= imp_len)
            st_d.phase = kgd_pkg::KGD_IDLE;
          else
            st_d.cnt = cnt_n;
        end
        default:
        begin
          st_d.phase = kgd_pkg::KGD_IDLE;
          st_d.cnt   = 9'h000;
        end
      endcase
    end

    // routing and latch selection
    rt_one  = st_q.route_line_a_reg[kgd_pkg::B_RT_ONE]
            | st_q.route_line_b_reg[kgd_pkg::B_RT_ONE];
    rt_two  = st_q.route_line_a_reg[kgd_pkg::B_RT_TWO]
            | st_q.route_line_b_reg[kgd_pkg::B_RT_TWO];
    lat_one = latch_sel && !mode_two && rt_one;
    lat_two = latch_sel && mode_two && rt_two;

    // status flags clear on read, a same-cycle event wins
    if (rd_clear)
    begin
      st_d.st_any    = 1'b0;
      st_d.st_one    = 1'b0;
      st_d.st_two    = 1'b0;
      st_d.latch_one = 1'b0;
      st_d.latch_two = 1'b0;
    end
    if (ev_one || ev_two)
    begin
      st_d.st_any = 1'b1;
      st_d.st_one = st_q.st_one | ev_one | (st_d.st_one & ~rd_clear);
      st_d.st_two = st_q.st_two | ev_two | (st_d.st_two & ~rd_clear);
      if (rd_clear)
      begin
        st_d.st_one = ev_one;
        st_d.st_two = ev_two;
      end
      // a pending latch freezes the captured sign and axis
      if (!(st_q.latch_one || st_q.latch_two) || rd_clear)
      begin
        st_d.st_sign = st_q.cap_neg;
        st_d.st_axis = 3'h0;
        st_d.st_axis[2 - st_q.axis] = 1'b1;
      end
    end

    // latched or pulsed interrupt sources
    if (ev_one && lat_one)
      st_d.latch_one = 1'b1;
    if (ev_two && lat_two)
      st_d.latch_two = 1'b1;
    if (sif.tick && st_q.pcnt != 9'h000)
    begin
      st_d.pcnt = 9'(st_q.pcnt - 9'h001);
      if (st_q.pcnt == 9'h001)
      begin
        st_d.pulse_one = 1'b0;
        st_d.pulse_two = 1'b0;
      end
    end
    if ((ev_one && !lat_one) || (ev_two && !lat_two))
    begin
      st_d.pcnt      = sil_len;
      st_d.pulse_one = ev_one && !lat_one;
      st_d.pulse_two = ev_two && !lat_two;
    end

    // line drive, both registered
    st_d.irq_a =
      ((st_d.pulse_one | st_d.latch_one)
        & st_q.route_line_a_reg[kgd_pkg::B_RT_ONE])
      | ((st_d.pulse_two | st_d.latch_two)
        & st_q.route_line_a_reg[kgd_pkg::B_RT_TWO]);
    st_d.irq_b =
      ((st_d.pulse_one | st_d.latch_one)
        & st_q.route_line_b_reg[kgd_pkg::B_RT_ONE])
      | ((st_d.pulse_two | st_d.latch_two)
        & st_q.route_line_b_reg[kgd_pkg::B_RT_TWO]);

    // read data, registered; unmapped offsets read zero
    st_d.rdata = 8'h00;
    if (reg_rd)
    begin
      case (reg_addr)
        kgd_pkg::OFS_CFG0:    st_d.rdata = st_q.knock_config_0;
        kgd_pkg::OFS_CFG1:    st_d.rdata = st_q.knock_config_1;
        kgd_pkg::OFS_CFG2:    st_d.rdata = st_q.knock_config_2;
        kgd_pkg::OFS_ZTHR:    st_d.rdata = st_q.zaxis_and_orient_threshold;
        kgd_pkg::OFS_FUNC_EN: st_d.rdata = st_q.functions_enable;
        kgd_pkg::OFS_TIMING:  st_d.rdata = st_q.knock_timing_reg;
        kgd_pkg::OFS_MOTION:  st_d.rdata = st_q.motion_threshold_reg;
        kgd_pkg::OFS_ROUTE_A: st_d.rdata = st_q.route_line_a_reg;
        kgd_pkg::OFS_ROUTE_B: st_d.rdata = st_q.route_line_b_reg;
        kgd_pkg::OFS_STATUS:
          st_d.rdata = {1'b0, st_q.st_any, st_q.st_one, st_q.st_two,
                        st_q.st_sign, st_q.st_axis};
        kgd_pkg::OFS_ALLSRC:
          st_d.rdata = {5'h00, st_q.st_two, st_q.st_one, st_q.st_any};
        default:              st_d.rdata = 8'h00;
      endcase
    end
  end

  // one register for all state
  always_ff @(posedge clock or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_q       <= '0;
      st_q.phase <= kgd_pkg::KGD_IDLE;
      st_q.knock_config_0 <= kgd_pkg::RST_REG;
    end
    else
      st_q <= st_d;
  end

  assign reg_rdata  = st_q.rdata;
  assign irq_line_a = st_q.irq_a;
  assign irq_line_b = st_q.irq_b;

endmodule

// File: dv/kgd_top_assertions.sv
// port-level assertions for the knock gesture detector
`timescale 1ns/1ps
module kgd_chk
(
  input wire logic       clock,
  input wire logic       rst_b,
  input wire logic       reg_wr,
  input wire logic       reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic [7:0] reg_rdata,
  input wire logic       irq_line_a,
  input wire logic       irq_line_b
);
  logic       glob_q, lat_q, mode_q, rd1c_q, rds_q;
  logic [7:0] rta_q, rtb_q;
  logic       rds, one_lat;

  // status reads clear; latch only for routed single knocks in mode 0
  assign rds = reg_rd && (reg_addr == 8'h1c || reg_addr == 8'h1d);
  assign one_lat = lat_q && !mode_q && rta_q[6] && !rta_q[3];

  // shadow of config bits, so rules can be judged from the ports
  always_ff @(posedge clock or negedge rst_b)
    if (!rst_b)
    begin
      {glob_q, lat_q, mode_q, rd1c_q, rds_q} <= 5'h00;
      rta_q <= 8'h00;
      rtb_q <= 8'h00;
    end
    else
    begin
      rd1c_q <= reg_rd && reg_addr == 8'h1c;
      rds_q <= rds;
      if (reg_wr && reg_addr == 8'h17) lat_q <= reg_wdata[0];
      if (reg_wr && reg_addr == 8'h50) glob_q <= reg_wdata[7];
      if (reg_wr && reg_addr == 8'h5b) mode_q <= reg_wdata[7];
      if (reg_wr && reg_addr == 8'h5e) rta_q <= reg_wdata;
      if (reg_wr && reg_addr == 8'h5f) rtb_q <= reg_wdata;
    end

  default clocking @(posedge clock); endclocking
  default disable iff (!rst_b);

  property p_glob; $rose(irq_line_a) |-> glob_q; endproperty
  a_glob: assert property (p_glob)
    else $error("irq a rose with global enable off");
  property p_rt_a; $rose(irq_line_a) |-> rta_q[6] || rta_q[3]; endproperty
  a_rt_a: assert property (p_rt_a)
    else $error("irq a rose with no event routed");
  property p_rt_b; $rose(irq_line_b) |-> rtb_q[6] || rtb_q[3]; endproperty
  a_rt_b: assert property (p_rt_b)
    else $error("irq b rose with no event routed");
  property p_any;
    rd1c_q && (reg_rdata[5] || reg_rdata[4]) |-> reg_rdata[6];
  endproperty
  a_any: assert property (p_any)
    else $error("event flag without any flag");
  property p_axis; rd1c_q && reg_rdata[6] |-> $onehot(reg_rdata[2:0]);
  endproperty
  a_axis: assert property (p_axis)
    else $error("status axis flags not one-hot");
  property p_nodbl; rd1c_q && !mode_q |-> !reg_rdata[4]; endproperty
  a_nodbl: assert property (p_nodbl)
    else $error("double flag in single-only mode");
  property p_hold;
    irq_line_a && one_lat && !rds && !rds_q |=> irq_line_a;
  endproperty
  a_hold: assert property (p_hold)
    else $error("latched irq dropped without read");
  property p_clr; irq_line_a && one_lat && rds |-> ##[1:3] !irq_line_a;
  endproperty
  a_clr: assert property (p_clr)
    else $error("latched irq stayed after status read");

  c_a: cover property ($rose(irq_line_a));
  c_b: cover property ($rose(irq_line_b));
  c_dbl: cover property (rd1c_q && reg_rdata[4]);
endmodule

// File: dv/kgd_host.sv
// host-side register master driving the detector register port
`timescale 1ns/1ps
module kgd_host
(
  input  wire logic       clock,
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  input  wire logic [7:0] reg_rdata
);
  // idle bus at time zero
  initial
  begin
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
  end

  // one-cycle write; released lines get scrambled so no stale value helps
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    #1;
    reg_wr = 1'b1;
    reg_addr = a;
    reg_wdata = d;
    @(posedge clock);
    #1;
    reg_wr = 1'b0;
    reg_addr = ~a;
    reg_wdata = ~d;
  endtask

  // one-cycle read; data taken once the strobe edge has passed
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge clock);
    #1;
    reg_rd = 1'b1;
    reg_addr = a;
    @(posedge clock);
    #1;
    reg_rd = 1'b0;
    reg_addr = ~a;
    d = reg_rdata;
  endtask
endmodule

// File: dv/kgd_top_bench.sv
// self-checking bench for the knock gesture detector
`timescale 1ns/1ps
module kgd_top_bench;
  logic                       clock = 1'b0;
  logic                       rst_b = 1'b0;
  logic                       sample_valid = 1'b0;
  logic [kgd_pkg::SMP_W-1:0]  ax [3] = '{default: '0};
  logic                       reg_wr, reg_rd, irq_line_a, irq_line_b;
  logic [7:0]                 reg_addr, reg_wdata, reg_rdata, st;
  int                         cur [3] = '{0, 0, 0};
  int                         n_errors = 0;
  int                         checked = 0;
  int                         na, nb;
  logic [2:0]                 pa [6] = '{4, 2, 4, 1, 2, 1};
  int                         imn [4] = '{3, 6, 6, 10};
  int dt [5][5] = '{'{1,0,0,0,1}, '{1,0,0,20,0}, '{1,2,0,0,0},
                    '{0,0,0,0,0}, '{1,0,1,20,1}};

  always #25 clock = ~clock;

  kgd_top uut (.clock(clock), .rst_b(rst_b), .sample_valid(sample_valid),
    .accel_x(ax[0]), .accel_y(ax[1]), .accel_z(ax[2]), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .irq_line_a(irq_line_a),
    .irq_line_b(irq_line_b));
  kgd_host host (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));

  // comparison and verdict
  task automatic chk(input string nm, input logic [7:0] got, exp);
    checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // expected status byte and pulse length in samples
  function automatic logic [7:0] es(input logic two, neg,
                                    input logic [2:0] axb);
    return {2'b01, 1'b1, two, neg, axb};
  endfunction
  function automatic int sl(input int c);
    return (c == 0) ? 2 : 4 * c;
  endfunction
  function automatic int stp(input int c, t);
    return c + ((t - c > 2000) ? 2000 : (t - c < -2000) ? -2000 : t - c);
  endfunction

  // one sample every 4 clocks, irq lines counted at each sample
  task automatic smp();
    @(posedge clock);
    #1;
    foreach (ax[i]) ax[i] = cur[i][kgd_pkg::SMP_W-1:0];
    sample_valid = 1'b1;
    @(posedge clock);
    #1;
    sample_valid = 1'b0;
    na += (irq_line_a === 1'b1);
    nb += (irq_line_b === 1'b1);
    repeat (2) @(posedge clock);
    #1;
  endtask
  // slow moves keep the slope at or under 1000, far under threshold 2048
  task automatic glide(input int t, n);
    repeat (n)
    begin
      foreach (cur[i]) cur[i] = stp(cur[i], t);
      smp();
    end
  endtask
  // n steps over threshold on masked axes, then one flat sample
  task automatic knk(input logic [2:0] m, input int s, n);
    repeat (n)
    begin
      foreach (cur[i]) if (m[i]) cur[i] += s;
      smp();
    end
    smp();
  endtask
  task automatic cfg(input logic [7:0] c0, c1, tim, md, ra, rb, gl);
    host.wr(8'h50, 8'h00);
    host.wr(8'h17, c0);
    host.wr(8'h18, c1);
    host.wr(8'h19, 8'h02);
    host.wr(8'h1a, 8'h02);
    host.wr(8'h5a, tim);
    host.wr(8'h5b, md);
    host.wr(8'h5e, ra);
    host.wr(8'h5f, rb);
    host.wr(8'h50, gl);
    host.rd(8'h1d, st);
    na = 0;
    nb = 0;
  endtask

  // main sequence
  initial
  begin
    int v, a, s, r, ng;
    v = $urandom(5124);
    repeat (10) @(posedge clock);
    #1;
    rst_b = 1'b1;
    host.rd(8'h1c, st);
    chk("status_rst", st, 8'h00);
    host.wr(8'h1c, 8'hff);
    host.rd(8'h1c, st);
    chk("status_ro", st, 8'h00);
    host.rd(8'h33, st);
    chk("unmapped", st, 8'h00);
    cfg(8'h02, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00);
    knk(1, 10000, 1);
    glide(0, 5);
    host.rd(8'h1c, st);
    chk("global_off", st, 8'h00);
    cfg(8'h02, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h80);
    knk(1, 4096, 1);
    glide(0, 3);
    knk(2, -10000, 1);
    glide(0, 5);
    host.rd(8'h1c, st);
    chk("at_level", st, 8'h00);
    knk(1, -4098, 1);
    glide(0, 3);
    host.rd(8'h1c, st);
    chk("over_level", st, es(0, 1, 3'b100));
    // all axes hit at once: each order picks its own winner
    for (int p = 0; p < 6; p++)
    begin
      cfg(8'h0e, {p[2:0], 5'h02}, 8'h00, 8'h00, 8'h40, 8'h00, 8'h80);
      knk(7, -10000, 1);
      glide(0, 5);
      host.rd(8'h1c, st);
      chk("priority", st, es(0, 1, pa[p]));
    end
    // random single knocks, random line and silence length
    for (int k = 0; k < 8; k++)
    begin
      a = $urandom_range(2);
      s = $urandom_range(3);
      v = $urandom_range(20000, 5000);
      ng = $urandom_range(1);
      r = $urandom_range(1);
      cfg(8'h0e, 8'h02, 8'(s * 4), 8'h00, 8'(r * 64), 8'(64 - r * 64),
          8'h80);
      knk(3'b001 << a, ng ? -v : v, 1);
      glide(0, 12);
      host.rd(8'h1c, st);
      chk("single", st, es(0, ng[0], 3'b100 >> a));
      chk("pulse_a", 8'(na), 8'(r * sl(s)));
      chk("pulse_b", 8'(nb), 8'((1 - r) * sl(s)));
    end
    // overshoot held past the impact window is dropped
    for (int j = 0; j < 4; j++)
    begin
      cfg(8'h02, 8'h02, 8'(j / 2), 8'h00, 8'h00, 8'h00, 8'h80);
      glide(-25000, 13);
      knk(1, 5000, imn[j]);
      glide(0, 13);
      host.rd(8'h1c, st);
      chk("impact", st & 8'h70, (j % 2) ? 8'h00 : 8'h60);
    end
    // second knock: in gap, too late, inside silence, single-only mode
    foreach (dt[j])
    begin
      cfg(8'h02, 8'h02, 8'(dt[j][2] * 16 + dt[j][1] * 4),
          8'(dt[j][0] * 128), 8'h00, 8'h08, 8'h80);
      knk(1, -10000, 1);
      glide(0, 5);
      repeat (dt[j][3]) smp();
      knk(1, -10000, 1);
      glide(0, 5);
      host.rd(8'h1c, st);
      chk("double", st, es(dt[j][4], 1, 3'b100));
      chk("pulse_two", 8'(nb), 8'(dt[j][4] * sl(dt[j][1])));
    end
    // latched line holds the first capture until the status read
    cfg(8'h0b, 8'h02, 8'h00, 8'h00, 8'h40, 8'h00, 8'h80);
    knk(1, -10000, 1);
    glide(0, 20);
    knk(4, 10000, 1);
    glide(0, 5);
    chk("latched", irq_line_a, 8'h01);
    host.rd(8'h1c, st);
    chk("held", st, es(0, 1, 3'b100));
    repeat (3) @(posedge clock);
    #1;
    chk("released", irq_line_a, 8'h00);
    cfg(8'h0b, 8'h02, 8'h00, 8'h80, 8'h40, 8'h00, 8'h80);
    knk(1, -10000, 1);
    glide(0, 8);
    chk("mode1_pulse", 8'(na), 8'(sl(0)));
    host.rd(8'h1d, st);
    chk("combined", st, 8'h03);
    cfg(8'h0b, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00, 8'h80);
    knk(1, -10000, 1);
    glide(0, 5);
    knk(4, 10000, 1);
    glide(0, 5);
    host.rd(8'h1c, st);
    chk("unrouted", st, es(0, 0, 3'b001));
    complete_run();
  end

  // cut a hang well past the expected run length
  initial
  begin
    #(50 * 40000);
    n_errors++;
    complete_run();
  end
endmodule

bind kgd_top kgd_chk u_chk (.clock(clock), .rst_b(rst_b), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_rdata(reg_rdata), .irq_line_a(irq_line_a), .irq_line_b(irq_line_b));
